// ==== src/cmc_pkg.sv ====
// package: register map, field layout and timing constants of the cache/memory csr bank
package cmc_pkg;
  localparam logic [3:0] CMC_OFF_TAG_MASK   = 4'h0;
  localparam logic [3:0] CMC_OFF_ERR_LOW    = 4'h1;
  localparam logic [3:0] CMC_OFF_ERR_HIGH   = 4'h2;
  localparam logic [3:0] CMC_OFF_LOCK_LOW   = 4'h3;
  localparam logic [3:0] CMC_OFF_LOCK_HIGH  = 4'h4;
  localparam logic [3:0] CMC_OFF_FRAME_PTR  = 4'h5;
  localparam logic [3:0] CMC_OFF_PRES_LOW   = 4'h6;
  localparam logic [3:0] CMC_OFF_ERR_STATUS = 4'h7;

  localparam int CMC_HIGH_BITS   = 13;
  localparam int CMC_COL_LSB     = 0;
  localparam int CMC_ROW_LSB     = 5;
  localparam int CMC_SUB_BIT     = 14;
  localparam int CMC_STAT_MULT   = 0;
  localparam int CMC_STAT_TAP    = 1;
  localparam int CMC_STAT_TCP    = 2;
  localparam int CMC_STAT_NXM    = 3;
  localparam int CMC_STAT_LOCKED = 4;

  localparam logic [15:0] CMC_FRAME_RW_MASK = 16'h7fff;
  localparam logic [15:0] CMC_PD_VALID_CYCLES = 16'h0094;
  localparam logic [15:0] CMC_ZERO16 = 16'h0000;

  typedef struct packed {
    logic [33:5] addr;
    logic        tap_err;
    logic        tcp_err;
    logic        nxm_err;
    logic        victim;
    logic [33:5] orig_addr;
  } cmc_err_event_t;

  typedef struct packed {
    logic [4:0] col;
    logic [8:0] row;
    logic       use_alt;
  } cmc_video_ptr_t;
endpackage : cmc_pkg

// ==== src/cmc_csr_bank.sv ====
// cache and memory controller csr bank with tag compare, error and lock capture, video pointer
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
//
// Contract
// [R01] set mask bit: compare system address bit with stored tag bit on probe
// [R02] clear mask bit: skip compare, stored tag bit taken as low
// [R03] mask bits 15:1 map to tag bits 31:17; bit 0 no meaning
// [R04] mask register readable and writable, no defined reset value
// [R05] software forms mask as AND of cache and memory size patterns
// [R06] cache pattern: one leading set bit per halving below 4 GB
// [R07] memory pattern: one leading clear bit per halving below 4 GB
// [R08] upper mask bits optional; small systems may clear them
// [R09] tag parity or nonexistent memory error latches address bits 20:5
// [R10] victim read error captures originating transaction address
// [R11] high error register holds address bits 33:21 in bits 12:0
// [R12] error address registers read-only, not reset, valid with error flag
// [R13] last load-locked address bits 20:5 kept in low lock register
// [R14] locked address bits 33:21 kept in bits 12:0 of high lock register
// [R15] frame pointer copied to display pointer at each full serial transfer
// [R16] column field 4:0 drives column address 6:2 on serial loads
// [R17] row field 13:5 gives frame buffer start row
// [R18] subbank enabled and bit set: alternate row strobe; bit 15 zero
// [R19] low presence register shows stream bits 15:0
// [R20] presence data valid 148 clocks after reset release
// [R21] locked error address held; later errors set only multiple-error flag
// [R22] writes to read-only registers ignored; reserved bits read zero
module cmc_csr_bank
  import cmc_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           rst_b,
  input  wire logic [3:0]     reg_addr,
  input  wire logic [15:0]    reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic      [15:0]    reg_rdata,
  input  wire logic [33:5]    system_address_bus,
  input  wire logic           tag_probe,
  input  wire logic [31:17]   cache_tag_address,
  output logic                tag_match,
  input  wire cmc_err_event_t err_event,
  input  wire logic           load_locked_access,
  input  wire logic           serial_full_start,
  input  wire logic           serial_load,
  input  wire logic           video_bank_subbank_enable,
  output cmc_video_ptr_t      display_ptr,
  output logic      [6:2]     serial_col_addr,
  output logic                primary_row_strobe_n,
  output logic                alternate_row_strobe_n,
  input  wire logic [15:0]    presence_stream_low,
  output logic                presence_valid
);

  // ***********************************************************
  // register decode
  // ***********************************************************
  logic [15:0]  tag_mask_q;
  logic [15:0]  err_low_q;
  logic [12:0]  err_high_q;
  logic [15:0]  lock_low_q;
  logic [12:0]  lock_high_q;
  logic [15:0]  frame_q;
  logic         mult_q;
  logic         tap_q;
  logic         tcp_q;
  logic         nxm_q;
  logic [15:0]  pd_cnt_q;
  logic [15:0]  rdata_q;
  cmc_video_ptr_t disp_q;
  logic [6:2]   col_q;
  logic         pri_n_q;
  logic         alt_n_q;
  logic         probe_q;
  logic         match_q;

  wire wr_mask   = reg_wr && (reg_addr == CMC_OFF_TAG_MASK);
  wire wr_frame  = reg_wr && (reg_addr == CMC_OFF_FRAME_PTR);
  wire wr_status = reg_wr && (reg_addr == CMC_OFF_ERR_STATUS);

  wire any_err     = err_event.tap_err || err_event.tcp_err || err_event.nxm_err;
  wire addr_locked = tap_q || tcp_q || nxm_q;
  // victim reads report the transaction that evicted them, not the victim line
  wire [33:5] err_addr = err_event.victim ? err_event.orig_addr : err_event.addr; // R10

  // write-one-to-clear; a new event in the same cycle wins over the clear of the multiple-error flag only
  wire clr_mult = wr_status && reg_wdata[CMC_STAT_MULT];
  wire clr_tap  = wr_status && reg_wdata[CMC_STAT_TAP];
  wire clr_tcp  = wr_status && reg_wdata[CMC_STAT_TCP];
  wire clr_nxm  = wr_status && reg_wdata[CMC_STAT_NXM];
  wire capture  = any_err && !addr_locked;                       // R21
  wire set_mult = any_err && addr_locked;                        // R21

  wire [15:0] status_word = {11'h000, addr_locked, nxm_q, tcp_q, tap_q, mult_q};
  wire        pd_done     = (pd_cnt_q == CMC_PD_VALID_CYCLES);

  wire [15:0] rd_mux =
    (reg_addr == CMC_OFF_TAG_MASK)   ? tag_mask_q :
    (reg_addr == CMC_OFF_ERR_LOW)    ? err_low_q :                    // R12
    (reg_addr == CMC_OFF_ERR_HIGH)   ? {3'h0, err_high_q} :           // R22
    (reg_addr == CMC_OFF_LOCK_LOW)   ? lock_low_q :
    (reg_addr == CMC_OFF_LOCK_HIGH)  ? {3'h0, lock_high_q} :
    (reg_addr == CMC_OFF_FRAME_PTR)  ? (frame_q & CMC_FRAME_RW_MASK) : // R18
    (reg_addr == CMC_OFF_PRES_LOW)   ? presence_stream_low :          // R19
    (reg_addr == CMC_OFF_ERR_STATUS) ? status_word : CMC_ZERO16;

  // ***********************************************************
  // uninitialised data registers (no reset by design)
  // ***********************************************************
  always_ff @(posedge mclk) begin
    if (wr_mask) tag_mask_q <= reg_wdata;                           // R04
    if (wr_frame) frame_q <= reg_wdata & CMC_FRAME_RW_MASK;         // R18
    if (capture) begin
      err_low_q  <= err_addr[20:5];                                 // R09
      err_high_q <= err_addr[33:21];                                // R11
    end
    if (load_locked_access) begin
      lock_low_q  <= system_address_bus[20:5];                      // R13
      lock_high_q <= system_address_bus[33:21];                     // R14
    end
  end

  // ***********************************************************
  // tag compare
  // ***********************************************************
  // masked bits are cleared on both the tag and the bus side, so they always compare equal
  wire [31:17] tag_eff = cache_tag_address & tag_mask_q[15:1];      // R02 R03
  wire [31:17] adr_eff = system_address_bus[31:17] & tag_mask_q[15:1];
  wire         cmp_eq  = (tag_eff == adr_eff);                      // R01
  assign tag_match = match_q;

  // ***********************************************************
  // video pointer
  // ***********************************************************
  wire alt_sel = video_bank_subbank_enable && frame_q[CMC_SUB_BIT];  // R18

  // ***********************************************************
  // controlled state
  // ***********************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mult_q   <= 1'b0;
      tap_q    <= 1'b0;
      tcp_q    <= 1'b0;
      nxm_q    <= 1'b0;
      pd_cnt_q <= 16'h0000;
      rdata_q  <= 16'h0000;
      disp_q   <= '0;
      col_q    <= 5'h00;
      pri_n_q  <= 1'b1;
      alt_n_q  <= 1'b1;
      probe_q  <= 1'b0;
      match_q  <= 1'b0;
    end else begin
      mult_q <= set_mult | (mult_q & ~clr_mult);                     // R21
      tap_q  <= (capture & err_event.tap_err) | (tap_q & ~clr_tap);  // R09
      tcp_q  <= (capture & err_event.tcp_err) | (tcp_q & ~clr_tcp);
      nxm_q  <= (capture & err_event.nxm_err) | (nxm_q & ~clr_nxm);
      if (!pd_done) pd_cnt_q <= pd_cnt_q + 16'h0001;                 // R20
      rdata_q <= reg_rd ? rd_mux : 16'h0000;
      if (serial_full_start) begin
        disp_q.col     <= frame_q[CMC_ROW_LSB-1:CMC_COL_LSB];        // R15
        disp_q.row     <= frame_q[CMC_SUB_BIT-1:CMC_ROW_LSB];        // R17
        disp_q.use_alt <= alt_sel;
      end
      if (serial_load) col_q <= frame_q[CMC_ROW_LSB-1:CMC_COL_LSB];  // R16
      pri_n_q <= ~(serial_full_start && !alt_sel);                  // R18
      alt_n_q <= ~(serial_full_start && alt_sel);
      probe_q <= tag_probe;
      match_q <= tag_probe ? cmp_eq : 1'b0;
    end
  end

  assign reg_rdata              = rdata_q;
  assign display_ptr            = disp_q;
  assign serial_col_addr        = col_q;
  assign primary_row_strobe_n   = pri_n_q;
  assign alternate_row_strobe_n = alt_n_q;
  assign presence_valid         = pd_done;

  // ***********************************************************
  // assertions
  // ***********************************************************
  sequence s_err_capt;
    capture ##1 1'b1;
  endsequence

  a_tag_match_set: assert property (@(posedge mclk) disable iff (!rst_b)
    tag_probe && (tag_mask_q[15:1] == 15'h7fff) && (cache_tag_address ==
    system_address_bus[31:17]) |=> tag_match) else $error("full compare miss"); // R01
  a_tag_skip_bits: assert property (@(posedge mclk) disable iff (!rst_b)
    tag_probe && (tag_mask_q[15:1] == 15'h0000) |=> tag_match)
    else $error("masked compare failed"); // R02
  a_tag_map_order: assert property (@(posedge mclk) disable iff (!rst_b)
    tag_probe && (((cache_tag_address ^ system_address_bus[31:17]) & tag_mask_q[15:1])
    != 15'h0000) |=> !tag_match) else $error("mismatch reported as hit"); // R03
  a_mask_write_rb: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_mask ##1 (reg_rd && reg_addr == CMC_OFF_TAG_MASK && !reg_wr)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("mask readback wrong"); // R04
  a_err_low_capt: assert property (@(posedge mclk) disable iff (!rst_b)
    capture |=> err_low_q == $past(err_addr[20:5])) else $error("low err addr"); // R09
  a_err_victim_orig: assert property (@(posedge mclk) disable iff (!rst_b)
    capture && err_event.victim |=> err_high_q == $past(err_event.orig_addr[33:21]))
    else $error("victim address latched"); // R10
  a_err_high_capt: assert property (@(posedge mclk) disable iff (!rst_b)
    s_err_capt |-> err_high_q == $past(err_addr[33:21])) else $error("high err addr"); // R11
  a_err_ro_write: assert property (@(posedge mclk) disable iff (!rst_b)
    reg_wr && reg_addr == CMC_OFF_ERR_LOW && !capture |=> $stable(err_low_q))
    else $error("ro register written"); // R12
  a_lock_low_rec: assert property (@(posedge mclk) disable iff (!rst_b)
    load_locked_access |=> lock_low_q == $past(system_address_bus[20:5]))
    else $error("lock low wrong"); // R13
  a_lock_high_rec: assert property (@(posedge mclk) disable iff (!rst_b)
    load_locked_access |=> lock_high_q == $past(system_address_bus[33:21]))
    else $error("lock high wrong"); // R14
  a_disp_ptr_load: assert property (@(posedge mclk) disable iff (!rst_b)
    serial_full_start |=> display_ptr.col == $past(frame_q[4:0]))
    else $error("display pointer not loaded"); // R15
  a_serial_col: assert property (@(posedge mclk) disable iff (!rst_b)
    serial_load |=> serial_col_addr == $past(frame_q[4:0])) else $error("column wrong"); // R16
  a_disp_row: assert property (@(posedge mclk) disable iff (!rst_b)
    serial_full_start |=> display_ptr.row == $past(frame_q[13:5])) else $error("row ptr"); // R17
  a_alt_strobe: assert property (@(posedge mclk) disable iff (!rst_b)
    serial_full_start && video_bank_subbank_enable && frame_q[14]
    |=> !alternate_row_strobe_n && primary_row_strobe_n) else $error("strobe select"); // R18
  a_pres_read: assert property (@(posedge mclk) disable iff (!rst_b)
    reg_rd && reg_addr == CMC_OFF_PRES_LOW |=> reg_rdata == $past(presence_stream_low))
    else $error("presence read"); // R19
  a_pres_timing: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(presence_valid) |-> pd_cnt_q == CMC_PD_VALID_CYCLES)
    else $error("presence timing"); // R20
  a_err_lock_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    any_err && addr_locked |=> mult_q && $stable(err_low_q)) else $error("lock broken"); // R21
  a_rsvd_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    reg_rd && reg_addr == CMC_OFF_ERR_HIGH |=> reg_rdata[15:13] == 3'h0)
    else $error("reserved bits set"); // R22

  // ***********************************************************
  // assertion helpers
  // ***********************************************************
  // free cycle count since release, kept apart from the presence counter
  // so the presence timing is held against an independent reference
  logic [15:0]  rel_cnt_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rel_cnt_q <= 16'h0000;
    end else if (rel_cnt_q != 16'hffff) begin
      rel_cnt_q <= rel_cnt_q + 16'h0001;
    end
  end

  sequence s_alt_launch;
    serial_full_start && alt_sel ##1 !serial_full_start;
  endsequence

  sequence s_pri_launch;
    serial_full_start && !alt_sel ##1 !serial_full_start;
  endsequence

  sequence s_alt_pulse;
    !alternate_row_strobe_n && primary_row_strobe_n ##1 alternate_row_strobe_n;
  endsequence

  sequence s_pri_pulse;
    !primary_row_strobe_n && alternate_row_strobe_n ##1 primary_row_strobe_n;
  endsequence

  // ***********************************************************
  // register bus assertions
  // ***********************************************************
  a_rdata_stands: assert property (@(posedge mclk) disable iff (!rst_b) // R22
    !$past(reg_rd) |-> reg_rdata == CMC_ZERO16)
    else $error("read data outside its cycle");

  a_unmapped_zero: assert property (@(posedge mclk) disable iff (!rst_b) // R22
    reg_rd && reg_addr > CMC_OFF_ERR_STATUS |=> reg_rdata == CMC_ZERO16)
    else $error("unmapped index read nonzero");

  a_stat_rsvd: assert property (@(posedge mclk) disable iff (!rst_b) // R22
    reg_rd && reg_addr == CMC_OFF_ERR_STATUS |=> reg_rdata[15:5] == 11'h000)
    else $error("status reserved bits set");

  a_lock_high_rsvd: assert property (@(posedge mclk) disable iff (!rst_b) // R22
    reg_rd && reg_addr == CMC_OFF_LOCK_HIGH |=> reg_rdata[15:13] == 3'h0)
    else $error("lock high reserved bits set");

  a_frame_rd_rsvd: assert property (@(posedge mclk) disable iff (!rst_b) // R18
    reg_rd && reg_addr == CMC_OFF_FRAME_PTR |=> !reg_rdata[15])
    else $error("frame reserved bit read set");

  a_frame_wr_rsvd: assert property (@(posedge mclk) disable iff (!rst_b) // R18
    wr_frame |=> !frame_q[15])
    else $error("frame reserved bit stored");

  a_lock_ro_write: assert property (@(posedge mclk) disable iff (!rst_b) // R22
    reg_wr && reg_addr == CMC_OFF_LOCK_LOW && !load_locked_access
    |=> $stable(lock_low_q))
    else $error("lock register written");

  a_err_high_ro: assert property (@(posedge mclk) disable iff (!rst_b) // R12
    reg_wr && reg_addr == CMC_OFF_ERR_HIGH && !capture |=> $stable(err_high_q))
    else $error("error high register written");

  // ***********************************************************
  // error capture assertions
  // ***********************************************************
  a_tap_capture: assert property (@(posedge mclk) disable iff (!rst_b) // R09
    capture && err_event.tap_err |=> tap_q)
    else $error("tag address parity flag missed");

  a_tcp_capture: assert property (@(posedge mclk) disable iff (!rst_b) // R09
    capture && err_event.tcp_err |=> tcp_q)
    else $error("tag control parity flag missed");

  a_nxm_capture: assert property (@(posedge mclk) disable iff (!rst_b) // R09
    capture && err_event.nxm_err |=> nxm_q)
    else $error("nonexistent memory flag missed");

  a_victim_low: assert property (@(posedge mclk) disable iff (!rst_b) // R10
    capture && err_event.victim |=> err_low_q == $past(err_event.orig_addr[20:5]))
    else $error("victim low address latched");

  a_err_low_held: assert property (@(posedge mclk) disable iff (!rst_b) // R21
    addr_locked |=> $stable(err_low_q))
    else $error("locked low address moved");

  a_flags_frozen: assert property (@(posedge mclk) disable iff (!rst_b) // R21
    any_err && addr_locked && !wr_status
    |=> {tap_q, tcp_q, nxm_q} == $past({tap_q, tcp_q, nxm_q}))
    else $error("later error touched cause flags");

  a_unlock_release: assert property (@(posedge mclk) disable iff (!rst_b) // R21
    wr_status && reg_wdata[CMC_STAT_NXM:CMC_STAT_TAP] == 3'h7 && !any_err
    |=> !addr_locked)
    else $error("clearing all flags kept the lock");

  a_mult_clear: assert property (@(posedge mclk) disable iff (!rst_b) // R21
    clr_mult && !set_mult |=> !mult_q)
    else $error("multiple-error flag not cleared");

  // ***********************************************************
  // tag, video and presence assertions
  // ***********************************************************
  a_match_probe: assert property (@(posedge mclk) disable iff (!rst_b) // R01
    tag_match |-> probe_q)
    else $error("match without probe");

  a_strobe_excl: assert property (@(posedge mclk) disable iff (!rst_b) // R18
    primary_row_strobe_n || alternate_row_strobe_n)
    else $error("both row strobes low");

  a_alt_pulse: assert property (@(posedge mclk) disable iff (!rst_b) // R18
    s_alt_launch |-> s_alt_pulse)
    else $error("alternate strobe pulse shape");

  a_pri_pulse: assert property (@(posedge mclk) disable iff (!rst_b) // R18
    s_pri_launch |-> s_pri_pulse)
    else $error("primary strobe pulse shape");

  a_sub_ignored: assert property (@(posedge mclk) disable iff (!rst_b) // R18
    serial_full_start && !video_bank_subbank_enable |=> alternate_row_strobe_n)
    else $error("subbank bit used while disabled");

  a_disp_alt: assert property (@(posedge mclk) disable iff (!rst_b) // R18
    serial_full_start |=> display_ptr.use_alt ==
    $past(video_bank_subbank_enable && frame_q[CMC_SUB_BIT]))
    else $error("display subbank wrong");

  a_disp_hold: assert property (@(posedge mclk) disable iff (!rst_b) // R15
    !serial_full_start |=> $stable(display_ptr))
    else $error("display pointer moved");

  a_col_hold: assert property (@(posedge mclk) disable iff (!rst_b) // R16
    !serial_load |=> $stable(serial_col_addr))
    else $error("column moved");

  a_pres_hold: assert property (@(posedge mclk) disable iff (!rst_b) // R20
    presence_valid |=> presence_valid)
    else $error("presence valid dropped");

  a_pres_count: assert property (@(posedge mclk) disable iff (!rst_b) // R20
    presence_valid == (rel_cnt_q >= CMC_PD_VALID_CYCLES))
    else $error("presence valid off count");

endmodule : cmc_csr_bank

// ==== tb/tb_cmc_csr_bank.sv ====
// self-checking bench for the cache/memory controller csr bank
`timescale 1ns/1ps
module tb_cmc_csr_bank;
  import cmc_pkg::*;
  logic           mclk = 1'b0;
  logic           rst_b, reg_wr, reg_rd, tag_probe, load_locked_access;
  logic           serial_full_start, serial_load, video_bank_subbank_enable;
  logic           tag_match, primary_row_strobe_n, alternate_row_strobe_n, presence_valid;
  logic [3:0]     reg_addr;
  logic [15:0]    reg_wdata, reg_rdata, presence_stream_low, fr;
  logic [33:5]    system_address_bus, sa, sb, oa;
  logic [31:17]   cache_tag_address, dx;
  logic [6:2]     serial_col_addr;
  cmc_err_event_t err_event;
  cmc_video_ptr_t display_ptr;
  logic [31:0]    lfsr = 32'hdbb42883;
  logic [31:0]    r;
  logic [15:0]    rd_exp[$], tm_exp[$];
  logic           rd_d, pr_d, alt;
  int             fail_count = 0;
  int             cmp_count = 0;

  cmc_csr_bank dut_u (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .system_address_bus, .tag_probe, .cache_tag_address, .tag_match, .err_event,
    .load_locked_access, .serial_full_start, .serial_load, .video_bank_subbank_enable,
    .display_ptr, .serial_col_addr, .primary_row_strobe_n, .alternate_row_strobe_n,
    .presence_stream_low, .presence_valid);

  always #25 mclk = ~mclk;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  // bus tasks start just after a rising edge; the idle cycle keeps strobes single-assigned
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    rd_exp.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask : rd

  task automatic err(input logic [33:5] ad, input logic [2:0] f, input logic v);
    err_event <= {ad, f, v, oa};
    @(posedge mclk);
    err_event <= '0;
    @(posedge mclk);
  endtask : err

  // results show one cycle after their request edge
  always @(posedge mclk) begin
    rd_d <= reg_rd;
    pr_d <= tag_probe;
  end
  always @(negedge mclk) begin
    if (rd_d === 1'b1) check(reg_rdata, rd_exp.pop_front());
    else if (rd_d === 1'b0) check(reg_rdata, 16'h0000);
    if (pr_d === 1'b1) check({15'h0, tag_match}, tm_exp.pop_front());
    else if (pr_d === 1'b0) check({15'h0, tag_match}, 16'h0000);
  end

  initial begin
    repeat (3000) @(posedge mclk);
    fail_count++;
    complete_run();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {reg_wr, reg_rd, tag_probe, load_locked_access, serial_full_start, serial_load} = '0;
    {video_bank_subbank_enable, reg_addr, reg_wdata, system_address_bus} = '0;
    cache_tag_address = '0;
    err_event = '0;
    oa = '0;
    rst_b = 1'b0;
    r = rnd();
    presence_stream_low = r[15:0];
    @(negedge mclk);
    check({13'h0, tag_match, primary_row_strobe_n, alternate_row_strobe_n}, 16'h0003);
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (147) @(posedge mclk);
    @(negedge mclk);
    check({15'h0, presence_valid}, 16'h0000);
    @(posedge mclk);
    @(negedge mclk);
    check({15'h0, presence_valid}, 16'h0001);
    @(posedge mclk);
    rd(CMC_OFF_PRES_LOW, r[15:0]);
    rd(4'h9, 16'h0000);
    $display("test presence done");
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      fr = (~(16'hffff >> r[3:0]) & (16'hfffe >> r[7:4]) & 16'hfffe) | {15'h0, r[8]};
      // write then read back with no idle cycle between the strobes
      reg_addr <= CMC_OFF_TAG_MASK;
      reg_wdata <= fr;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      rd(CMC_OFF_TAG_MASK, fr);
      r = rnd();
      sa = r[28:0];
      r = rnd();
      dx = r[31] ? (r[14:0] & ~fr[15:1]) : r[14:0];
      tm_exp.push_back({15'h0, (dx & fr[15:1]) == 15'h0});
      system_address_bus <= sa;
      cache_tag_address <= sa[31:17] ^ dx;
      tag_probe <= 1'b1;
      @(posedge mclk);
      tag_probe <= 1'b0;
      @(posedge mclk);
    end
    $display("test tag compare done");
    r = rnd();
    sa = r[28:0];
    r = rnd();
    sb = r[28:0];
    err(sa, 3'b101, 1'b0);
    rd(CMC_OFF_ERR_LOW, sa[20:5]);
    wr(CMC_OFF_ERR_HIGH, ~{3'h0, sa[33:21]});
    rd(CMC_OFF_ERR_HIGH, {3'h0, sa[33:21]});
    err(sb, 3'b001, 1'b0);
    wr(CMC_OFF_ERR_LOW, ~sa[20:5]);
    rd(CMC_OFF_ERR_LOW, sa[20:5]);
    rd(CMC_OFF_ERR_STATUS, 16'h001b);
    wr(CMC_OFF_ERR_STATUS, 16'h000f);
    rd(CMC_OFF_ERR_STATUS, 16'h0000);
    r = rnd();
    oa = r[28:0];
    err(sb, 3'b010, 1'b1);
    rd(CMC_OFF_ERR_LOW, oa[20:5]);
    rd(CMC_OFF_ERR_HIGH, {3'h0, oa[33:21]});
    rd(CMC_OFF_ERR_STATUS, 16'h0014);
    $display("test error capture done");
    system_address_bus <= sb;
    load_locked_access <= 1'b1;
    @(posedge mclk);
    load_locked_access <= 1'b0;
    @(posedge mclk);
    wr(CMC_OFF_LOCK_LOW, ~sb[20:5]);
    rd(CMC_OFF_LOCK_LOW, sb[20:5]);
    rd(CMC_OFF_LOCK_HIGH, {3'h0, sb[33:21]});
    $display("test lock capture done");
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      fr = {r[15], i[1], r[13:0]};
      alt = i[0] & i[1];
      video_bank_subbank_enable <= i[0];
      wr(CMC_OFF_FRAME_PTR, fr);
      rd(CMC_OFF_FRAME_PTR, fr & 16'h7fff);
      serial_full_start <= 1'b1;
      @(posedge mclk);
      serial_full_start <= 1'b0;
      serial_load <= 1'b1;
      @(negedge mclk);
      check({1'b0, display_ptr}, {1'b0, fr[4:0], fr[13:5], alt});
      check({14'h0, primary_row_strobe_n, alternate_row_strobe_n}, {14'h0, alt, ~alt});
      @(posedge mclk);
      serial_load <= 1'b0;
      @(negedge mclk);
      check({11'h0, serial_col_addr}, {11'h0, fr[4:0]});
      check({14'h0, primary_row_strobe_n, alternate_row_strobe_n}, 16'h0003);
      @(posedge mclk);
    end
    $display("test video pointer done");
    repeat (2) @(posedge mclk);
    complete_run();
  end
endmodule : tb_cmc_csr_bank
